// *** rtl/mdm_modereg_cmd.sv ***
// Operation
// R1: revision byte one is read-only at mode address 06H.
// R2: revision byte two is read-only at mode address 07H.
// R3: address 08H returns type, density 512Mb and x32 width fields.
// R4: calibration codes FF, AB, 56, C3 start their calibration kind.
// R5: controller never writes a reserved calibration code; the bench writes reserved code 12H to address 0AH to check R6.
// R6: reserved calibration codes are ignored, no calibration starts.
// R7: calibration pin at supply rail ignores every calibration command.
// R8: bank mask bit n blocks self-refresh of bank n, zero enables.
// R9: upper four bank mask bits are ignored.
// R10: mask touches self-refresh only; auto-refresh covers all banks.
// R11: reading address 20H returns pattern A.
// R12: reading address 28H returns pattern B.
// R13: address 3FH is a write-only reset, data ignored.
// R14: chip select low, bit0 low, bit1 high decodes an activate.
// R15: controller activates first and waits row-to-column delay.
// R16: controller precharges before reactivating, keeps active and precharge times.
// R17: controller spaces activates by row cycle and row-to-row delays.
// R18: controller uses all-bank or single-bank precharge period accordingly.
// R19: chip select low, bit0 high, bit1 low is column access; bit2 reads.
// R20: burst length four bursts are never interrupted.
// R21: length 8/16 reads interrupted only by reads on even cycles.
// R22: start column from rising bits 6:5 and falling bits 9:1; the code takes falling bits 6:1.
// R23: first datum read latency clock cycles after the read edge.
// R24: strobe driven low one clock as preamble before first rise.
// R25: burst bits follow successive strobe edges, first on rising edge.
// R26: chip select high at the rising edge decodes nothing.
`timescale 1ns/1ps
`default_nettype none

module mdm_fifo #(
   parameter int W = 9,
   parameter int D = 8
) (
   // clock and reset
   input  wire logic         clk_sys,
   input  wire logic         rst_b,
   // fill side
   input  wire logic         in_valid,
   output logic              in_ready,
   input  wire logic [W-1:0] in_data,
   // drain side
   output logic              out_valid,
   input  wire logic         out_ready,
   output logic [W-1:0]      out_data
);
   localparam int AW = $clog2(D);
   typedef struct packed {
      logic [D-1:0][W-1:0] mem;
      logic [AW-1:0]       wp;
      logic [AW-1:0]       rp;
      logic [AW:0]         cnt;
   } mdm_fifo_st_t;
   mdm_fifo_st_t s;
   mdm_fifo_st_t next_s;
   logic         push;
   logic         pop;

   assign in_ready  = s.cnt != (AW+1)'(D);
   assign out_valid = s.cnt != '0;
   assign out_data  = s.mem[s.rp];
   assign push      = in_valid && in_ready;
   assign pop       = out_valid && out_ready;

   always_comb
   begin
      next_s = s;
      if (push)
      begin
         next_s.mem[s.wp] = in_data;
         next_s.wp        = s.wp + 1'b1;
      end
      if (pop)
         next_s.rp = s.rp + 1'b1;
      if (push && !pop)
         next_s.cnt = s.cnt + 1'b1;
      else if (pop && !push)
         next_s.cnt = s.cnt - 1'b1;
   end

   always_ff @(posedge clk_sys or negedge rst_b)
   begin
      if (!rst_b)
         s <= '0;
      else
         s <= next_s;
   end
endmodule // mdm_fifo

module mdm_modereg_cmd #(
   parameter logic [7:0] REV_ONE = 8'h5A,  // arbitrary value
   parameter logic [7:0] REV_TWO = 8'hA5   // arbitrary value
) (
   // clock and reset
   input  wire logic       clk_sys,
   input  wire logic       rst_b,
   // link from the controller
   input  wire logic       ck,
   input  wire logic       cs_b,
   input  wire logic [9:0] ca,
   input  wire logic       impedance_cal_pin_at_supply,
   // configuration held by the lower mode registers
   input  wire logic [3:0] read_latency,
   input  wire logic [5:0] burst_length,
   // read data pins
   output logic [7:0]      dq,
   output logic            dq_oe,
   output logic            dqs,
   output logic            dqs_oe,
   // events and state
   output logic            act_pulse,
   output logic [1:0]      act_bank,
   output logic [12:0]     act_row,
   output logic            cal_pulse,
   output logic [1:0]      cal_kind,
   output logic            soft_reset_pulse,
   output logic [3:0]      srf_bank_en,
   output logic [3:0]      arf_bank_en
);
   typedef struct packed {
      logic                ck_m, ck_s, ck_d, cs_m, cs_s, imp_m, imp_s;
      logic [9:0]          ca_m, ca_s, ca_r;
      logic                cs_r;
      logic [3:0]          srf, arf;
      logic                cal_p, rst_p, act_p;
      mdm_pkg::mdm_cal_t   cal_k;
      logic [1:0]          act_b;
      logic [12:0]         act_row;
      logic [4:0]          since;
      logic [5:0]          lr_len;
      logic                lr_id;
      logic [5:0]          fcnt;
      logic [7:0]          fval;
      logic                finc, fid, fqv, fqid;
      logic [5:0]          fqcnt;
      logic [7:0]          fqval;
      logic                pend, pid, qv, qid;
      logic [4:0]          plat, qgap;
      logic [5:0]          pbl, qbl, cur;
      logic                cid, dqs, dqs_oe, dq_oe;
      logic [7:0]          dq;
   } mdm_st_t;
   localparam mdm_st_t ST_RST = '{srf: mdm_pkg::SRF_EN_RST, arf: mdm_pkg::ARF_ALL, cal_k: mdm_pkg::MDM_CAL_INIT,
                                  default: '0};

   mdm_st_t    s;
   mdm_st_t    next_s;
   logic       rise, fall, cmd_ok, is_mode_wr, is_mrr, is_act, is_rd, busy, intr, rd_ok, mrr_ok;
   logic       launch, beat, drop, f_in_ready, f_valid;
   logic [7:0] ma, op, col;
   logic [5:0] two_k, cut, beats_now;
   logic [8:0] f_data;

   function automatic logic cal_known(input logic [7:0] c);
      cal_known = c == mdm_pkg::CAL_INIT || c == mdm_pkg::CAL_LONG ||
                  c == mdm_pkg::CAL_SHORT || c == mdm_pkg::CAL_RESET;
   endfunction

   function automatic logic [5:0] sat_sub(input logic [5:0] a, input logic [5:0] b);
      sat_sub = (a > b) ? a - b : 6'h00;
   endfunction

   function automatic logic [7:0] mrr_value(input logic [7:0] a);
      unique case (a)
         mdm_pkg::MA_REV_ONE:   mrr_value = REV_ONE;
         mdm_pkg::MA_REV_TWO:   mrr_value = REV_TWO;
         mdm_pkg::MA_GEOMETRY:  mrr_value = mdm_pkg::GEO_VALUE;
         mdm_pkg::MA_PATTERN_A: mrr_value = mdm_pkg::PATTERN_A;
         mdm_pkg::MA_PATTERN_B: mrr_value = mdm_pkg::PATTERN_B;
         default:               mrr_value = 8'h00;
      endcase
   endfunction

   // link pins are sampled on clk_sys; ck is roughly 16 system clocks per period
   assign rise   = s.ck_s && !s.ck_d;
   assign fall   = !s.ck_s && s.ck_d;
   assign cmd_ok = fall && !s.cs_r;  // R26
   assign ma     = {s.ca_s[1:0], s.ca_r[9:4]};
   assign op     = s.ca_s[9:2];
   assign col    = {s.ca_s[6:1], s.ca_r[6:5]};  // R22
   assign is_mode_wr = cmd_ok && s.ca_r[3:0] == mdm_pkg::CMD_MODE_WR;
   assign is_mrr = cmd_ok && s.ca_r[3:0] == mdm_pkg::CMD_MRR;
   assign is_act = cmd_ok && s.ca_r[1:0] == mdm_pkg::CMD_ACT;  // R14
   assign is_rd  = cmd_ok && s.ca_r[2:0] == mdm_pkg::CMD_RD;  // R19
   assign busy   = s.pend || s.cur != 6'h00;
   assign two_k  = {s.since, 1'b0};
   assign intr   = burst_length != mdm_pkg::BURST_FOUR && !s.since[0] && s.since >= mdm_pkg::INTR_MIN;  // R20 R21
   assign rd_ok  = is_rd && (!busy || intr);
   assign mrr_ok = is_mrr && !busy;
   assign cut    = (two_k < s.lr_len) ? s.lr_len - two_k : 6'h00;

   assign launch    = rise && s.pend && s.plat == mdm_pkg::LAUNCH_LAT;
   assign beats_now = launch ? s.pbl : s.cur;
   assign beat      = (rise || fall) && beats_now != 6'h00;
   // words of a truncated burst are discarded once that burst has ended
   assign drop      = !beat && s.cur == 6'h00 && f_valid && f_data[8] != (s.pend ? s.pid : s.cid);

   mdm_fifo #(
      .W (mdm_pkg::FIFO_W),
      .D (mdm_pkg::FIFO_D)
   ) u_fifo (
      .clk_sys   (clk_sys),
      .rst_b     (rst_b),
      .in_valid  (s.fcnt != 6'h00),
      .in_ready  (f_in_ready),
      .in_data   ({s.fid, s.fval}),
      .out_valid (f_valid),
      .out_ready (beat || drop),
      .out_data  (f_data)
   );

   always_comb
   begin
      next_s       = s;
      next_s.ck_m  = ck;
      next_s.ck_s  = s.ck_m;
      next_s.ck_d  = s.ck_s;
      next_s.cs_m  = cs_b;
      next_s.cs_s  = s.cs_m;
      next_s.ca_m  = ca;
      next_s.ca_s  = s.ca_m;
      next_s.imp_m = impedance_cal_pin_at_supply;
      next_s.imp_s = s.imp_m;
      next_s.cal_p = 1'b0;
      next_s.rst_p = 1'b0;
      next_s.act_p = 1'b0;
      if (rise)
      begin
         next_s.ca_r = s.ca_s;
         next_s.cs_r = s.cs_s;
         if (s.since != mdm_pkg::SINCE_MAX)
            next_s.since = s.since + 1'b1;
         if (s.pend)
            next_s.plat = s.plat - 1'b1;
      end

      // fill stalls while the fifo is full
      if (s.fcnt != 6'h00 && f_in_ready)
      begin
         next_s.fcnt = s.fcnt - 1'b1;
         next_s.fval = s.fval + {7'h00, s.finc};
      end
      if (next_s.fcnt == 6'h00 && s.fqv)
      begin
         next_s.fcnt = s.fqcnt;
         next_s.fval = s.fqval;
         next_s.fid  = s.fqid;
         next_s.finc = 1'b1;
         next_s.fqv  = 1'b0;
      end

      if (launch)  // R23
      begin
         next_s.cid  = s.pid;
         next_s.pend = s.qv;
         next_s.plat = s.qgap;
         next_s.pbl  = s.qbl;
         next_s.pid  = s.qid;
         next_s.qv   = 1'b0;
      end
      if (beat)  // R25
      begin
         next_s.dqs    = rise;
         next_s.dqs_oe = 1'b1;
         next_s.dq_oe  = 1'b1;
         next_s.dq     = f_data[7:0];
         next_s.cur    = beats_now - 1'b1;
      end
      else if (rise || fall)
      begin
         next_s.dqs    = 1'b0;
         next_s.dq_oe  = 1'b0;
         next_s.dqs_oe = next_s.pend && next_s.plat == mdm_pkg::LAUNCH_LAT;  // R24
      end

      if (is_mode_wr)
      begin
         unique case (ma)
            mdm_pkg::MA_CAL_CODE:
               if (cal_known(op) && !s.imp_s)  // R4 R6 R7
               begin
                  next_s.cal_p = 1'b1;
                  next_s.cal_k = op == mdm_pkg::CAL_INIT  ? mdm_pkg::MDM_CAL_INIT :
                                 op == mdm_pkg::CAL_LONG  ? mdm_pkg::MDM_CAL_LONG :
                                 op == mdm_pkg::CAL_SHORT ? mdm_pkg::MDM_CAL_SHORT : mdm_pkg::MDM_CAL_RESET;
               end
            mdm_pkg::MA_BANK_MASK: next_s.srf   = ~op[3:0];  // R8 R9 R10
            mdm_pkg::MA_SOFT_RST:  next_s.rst_p = 1'b1;  // R13
            default: ;
         endcase
      end
      if (is_act)  // R14
      begin
         next_s.act_p   = 1'b1;
         next_s.act_b   = s.ca_r[8:7];
         next_s.act_row = {s.ca_s[7:0], s.ca_r[6:2]};
      end
      if (rd_ok || mrr_ok)
      begin
         next_s.since = 5'h00;
         next_s.lr_id = ~s.lr_id;
         next_s.lr_len = rd_ok ? burst_length : mdm_pkg::MRR_BEATS;
      end
      if (rd_ok)
      begin
         if (busy && cut != 6'h00)  // R21
         begin
            if (s.qv)
               next_s.qbl = two_k;
            else if (s.pend)
               next_s.pbl = two_k;
            else
               next_s.cur = sat_sub(next_s.cur, cut);
            if (s.fqv)
               next_s.fqcnt = sat_sub(s.fqcnt, cut);
            else
               next_s.fcnt = sat_sub(next_s.fcnt, cut);
         end
         if (next_s.pend)
         begin
            next_s.qv   = 1'b1;
            next_s.qgap = {1'b0, read_latency - next_s.plat[3:0]};
            next_s.qbl  = burst_length;
            next_s.qid  = ~s.lr_id;
         end
         else
         begin
            next_s.pend = 1'b1;
            next_s.plat = {1'b0, read_latency};
            next_s.pbl  = burst_length;
            next_s.pid  = ~s.lr_id;
         end
         if (next_s.fcnt != 6'h00)
         begin
            next_s.fqv   = 1'b1;
            next_s.fqcnt = burst_length;
            next_s.fqval = col;
            next_s.fqid  = ~s.lr_id;
         end
         else
         begin
            next_s.fcnt = burst_length;
            next_s.fval = col;
            next_s.fid  = ~s.lr_id;
            next_s.finc = 1'b1;
         end
      end
      if (mrr_ok)  // R1 R2 R3 R11 R12
      begin
         next_s.pend = 1'b1;
         next_s.plat = {1'b0, read_latency};
         next_s.pbl  = mdm_pkg::MRR_BEATS;
         next_s.pid  = ~s.lr_id;
         next_s.fcnt = mdm_pkg::MRR_BEATS;
         next_s.fval = mrr_value(ma);
         next_s.fid  = ~s.lr_id;
         next_s.finc = 1'b0;
         next_s.fqv  = 1'b0;
      end
   end

   always_ff @(posedge clk_sys or negedge rst_b)
   begin
      if (!rst_b)
         s <= ST_RST;
      else
         s <= next_s;
   end

   assign dq               = s.dq;
   assign dq_oe            = s.dq_oe;
   assign dqs              = s.dqs;
   assign dqs_oe           = s.dqs_oe;
   assign act_pulse        = s.act_p;
   assign act_bank         = s.act_b;
   assign act_row          = s.act_row;
   assign cal_pulse        = s.cal_p;
   assign cal_kind         = s.cal_k;
   assign soft_reset_pulse = s.rst_p;
   assign srf_bank_en      = s.srf;
   assign arf_bank_en      = s.arf;

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_b);

   sequence s_preamble;
      !dqs && dqs_oe && !dq_oe;
   endsequence
   sequence s_first_beat;
      dqs && dqs_oe && dq_oe;
   endsequence

   property p_deselect;
      fall && s.cs_r |=> !act_pulse && !cal_pulse && !soft_reset_pulse;
   endproperty
   a_deselect: assert property (p_deselect) else $error("command decoded while deselected"); // R26
   property p_activate;
      is_act |=> act_pulse && act_bank == $past(s.ca_r[8:7]);
   endproperty
   a_activate: assert property (p_activate) else $error("activate not reported"); // R14
   property p_cal_ignore;
      is_mode_wr && ma == mdm_pkg::MA_CAL_CODE && (!cal_known(op) || s.imp_s) |=> !cal_pulse;
   endproperty
   a_cal_ignore: assert property (p_cal_ignore) else $error("ignored calibration started"); // R6
   property p_cal_short;
      is_mode_wr && ma == mdm_pkg::MA_CAL_CODE && op == mdm_pkg::CAL_SHORT && !s.imp_s
         |=> cal_pulse && cal_kind == mdm_pkg::MDM_CAL_SHORT;
   endproperty
   a_cal_short: assert property (p_cal_short) else $error("short calibration missed"); // R4
   property p_mask;
      is_mode_wr && ma == mdm_pkg::MA_BANK_MASK
         |=> srf_bank_en == ~$past(op[3:0]) && arf_bank_en == mdm_pkg::ARF_ALL;
   endproperty
   a_mask: assert property (p_mask) else $error("bank mask wrong"); // R8
   property p_geometry;
      mrr_ok && ma == mdm_pkg::MA_GEOMETRY |=> s.fval == mdm_pkg::GEO_VALUE && s.fcnt == mdm_pkg::MRR_BEATS;
   endproperty
   a_geometry: assert property (p_geometry) else $error("geometry byte wrong"); // R3
   property p_column;
      rd_ok && !busy |=> s.fval == $past(col) && s.pend;
   endproperty
   a_column: assert property (p_column) else $error("start column wrong"); // R22
   property p_preamble;
      rise && s.pend && s.plat == 5'h02 && s.cur == 6'h00 |=> s_preamble;
   endproperty
   a_preamble: assert property (p_preamble) else $error("no preamble"); // R24
   property p_launch;
      launch && f_valid |=> s_first_beat ##0 dq == $past(f_data[7:0]);
   endproperty
   a_launch: assert property (p_launch) else $error("first beat misaligned"); // R25
   property p_bl4;
      is_rd && busy && burst_length == mdm_pkg::BURST_FOUR |=> $stable(s.pid) && $stable(s.qv);
   endproperty
   a_bl4: assert property (p_bl4) else $error("length four burst interrupted"); // R20
endmodule // mdm_modereg_cmd

`default_nettype wire

// *** rtl/mdm_pkg.sv ***
`default_nettype none

package mdm_pkg;
   // mode register addresses
   localparam logic [7:0] MA_REV_ONE   = 8'h06;
   localparam logic [7:0] MA_REV_TWO   = 8'h07;
   localparam logic [7:0] MA_GEOMETRY  = 8'h08;
   localparam logic [7:0] MA_VEND_TEST = 8'h09;
   localparam logic [7:0] MA_CAL_CODE  = 8'h0A;
   localparam logic [7:0] MA_BANK_MASK = 8'h10;
   localparam logic [7:0] MA_PATTERN_A = 8'h20;
   localparam logic [7:0] MA_PATTERN_B = 8'h28;
   localparam logic [7:0] MA_SOFT_RST  = 8'h3F;

   // geometry byte fields: type [1:0], density [5:2], width [7:6]
   localparam logic [1:0] GEO_TYPE_S4   = 2'h0;
   localparam logic [3:0] GEO_DENS_512  = 4'h3;
   localparam logic [1:0] GEO_WIDTH_X32 = 2'h0;
   localparam logic [1:0] GEO_WIDTH_X16 = 2'h1;
   localparam logic [7:0] GEO_VALUE     = {GEO_WIDTH_X32, GEO_DENS_512, GEO_TYPE_S4};

   // calibration codes
   localparam logic [7:0] CAL_INIT  = 8'hFF;
   localparam logic [7:0] CAL_LONG  = 8'hAB;
   localparam logic [7:0] CAL_SHORT = 8'h56;
   localparam logic [7:0] CAL_RESET = 8'hC3;
   typedef enum logic [1:0] {MDM_CAL_INIT, MDM_CAL_LONG, MDM_CAL_SHORT, MDM_CAL_RESET} mdm_cal_t;

   // training patterns returned by pattern reads
   localparam logic [7:0] PATTERN_A = 8'h55;
   localparam logic [7:0] PATTERN_B = 8'h33;

   // command codes on the rising-edge half of the bus
   localparam logic [3:0] CMD_MODE_WR = 4'h0;
   localparam logic [3:0] CMD_MRR = 4'h8;
   localparam logic [1:0] CMD_ACT = 2'h2;
   localparam logic [2:0] CMD_RD  = 3'h5;

   // reset values and counts
   localparam logic [3:0] SRF_EN_RST  = 4'hF;
   localparam logic [3:0] ARF_ALL     = 4'hF;
   localparam logic [5:0] MRR_BEATS   = 6'h04;
   localparam logic [5:0] BURST_FOUR  = 6'h04;
   localparam logic [4:0] INTR_MIN    = 5'h02;
   localparam logic [4:0] SINCE_MAX   = 5'h1F;
   localparam logic [4:0] LAUNCH_LAT  = 5'h01;
   localparam int         FIFO_W      = 9;
   localparam int         FIFO_D      = 8;
endpackage

`default_nettype wire

// *** test/mdm_ctrl_model.sv ***
`timescale 1ns/1ps
`default_nettype none

module mdm_ctrl_model (
   // link pins toward the device
   output logic       ck,
   output logic       cs_b,
   output logic [9:0] ca
);
   localparam int Q = 20;

   initial
   begin
      ck = 1'b0;
      cs_b = 1'b1;
      ca = 10'h155;
   end

   // one command period; no precharge is ever sent, so each bank sees at most one activate
   // the select is left standing at the end so a following command drives each pin only once
   task automatic cmd(input logic [9:0] r, input logic [9:0] f, input logic sel);
      cs_b = !sel;
      ca = r;
      #Q ck = 1'b1;
      #Q ca = f;
      #Q ck = 1'b0;
      #Q;
   endtask

   // deselected periods keep ck running for bursts; the bus toggles so nothing stale lingers
   task automatic idle(input int n);
      cs_b = 1'b1;
      repeat (n)
      begin
         ca = ~ca;
         #Q ck = 1'b1;
         #Q ca = ~ca;
         #Q ck = 1'b0;
         #Q;
      end
   endtask
endmodule // mdm_ctrl_model

`default_nettype wire

// *** test/mdm_modereg_cmd_bench.sv ***
`timescale 1ns/1ps
`default_nettype none

module mdm_modereg_cmd_bench;
   localparam logic [7:0] REV1 = 8'h3C;  // arbitrary value
   localparam logic [7:0] REV2 = 8'h96;  // arbitrary value
   typedef struct packed {logic wr; logic [7:0] a; logic [7:0] d; logic [7:0] e;} mdm_row_t;

   logic            clk_sys, rst_b, cal_sup, dq_oe, dqs, dqs_oe, act_p, cal_p, sr_p;
   logic            prev_oe, prev_dqs, prev_doe, first_dqs;
   logic [3:0]      rd_lat, srf, arf;
   logic [5:0]      burst_len;
   logic [7:0]      dq;
   logic [1:0]      act_bank, cal_kind;
   logic [12:0]     act_row;
   wire logic       ck, cs_b;
   wire logic [9:0] ca;
   int              failures, comparisons, acts, cals, srs, rises, first_rise, pre_ok, n, k, base;
   logic [7:0]      beats[$];
   // write rows expect {cal pulse, reset pulse, cal_kind, srf_bank_en}
   mdm_row_t        rows[16] = '{
      '{1'b0, 8'h06, 8'h00, REV1},
      '{1'b0, 8'h07, 8'h00, REV2},
      '{1'b0, 8'h08, 8'h00, 8'h0C},
      '{1'b0, 8'h09, 8'h00, 8'h00},
      '{1'b0, 8'h20, 8'h00, mdm_pkg::PATTERN_A},
      '{1'b0, 8'h28, 8'h00, mdm_pkg::PATTERN_B},
      '{1'b0, 8'h3F, 8'h00, 8'h00},
      '{1'b1, 8'h0A, 8'hFF, 8'h8F},
      '{1'b1, 8'h0A, 8'hAB, 8'h9F},
      '{1'b1, 8'h0A, 8'h56, 8'hAF},
      '{1'b1, 8'h0A, 8'hC3, 8'hBF},
      '{1'b1, 8'h0A, 8'h12, 8'h3F},
      '{1'b1, 8'h10, 8'hA5, 8'h3A},
      '{1'b1, 8'h10, 8'hF0, 8'h3F},
      '{1'b1, 8'h10, 8'h0F, 8'h30},
      '{1'b1, 8'h3F, 8'h77, 8'h70}};

   mdm_ctrl_model mdm_ctrl_model_inst (.ck(ck), .cs_b(cs_b), .ca(ca));

   mdm_modereg_cmd #(.REV_ONE(REV1), .REV_TWO(REV2)) mdm_modereg_cmd_inst (
      .clk_sys(clk_sys), .rst_b(rst_b), .ck(ck), .cs_b(cs_b), .ca(ca),
      .impedance_cal_pin_at_supply(cal_sup), .read_latency(rd_lat), .burst_length(burst_len),
      .dq(dq), .dq_oe(dq_oe), .dqs(dqs), .dqs_oe(dqs_oe), .act_pulse(act_p),
      .act_bank(act_bank), .act_row(act_row), .cal_pulse(cal_p), .cal_kind(cal_kind),
      .soft_reset_pulse(sr_p), .srf_bank_en(srf), .arf_bank_en(arf));

   task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
      comparisons++;
      if (g !== e)
      begin
         failures++;
         $display("MISMATCH %s expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic chk_n(input string nm, input int e, input int g);
      comparisons++;
      if (g != e)
      begin
         failures++;
         $display("MISMATCH %s expected %0d seen %0d", nm, e, g);
      end
   endtask

   task automatic finish_test;
      $display("comparisons %0d failures %0d", comparisons, failures);
      if (failures == 0 && comparisons > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   task automatic mr(input logic [7:0] a, input logic [7:0] d, input logic rd);
      mdm_ctrl_model_inst.cmd({a[5:0], rd, 3'b000}, {d, a[7:6]}, 1'b1);
   endtask

   task automatic rdc(input logic [7:0] c);
      mdm_ctrl_model_inst.cmd({3'b000, c[1:0], 5'b00101}, {3'b000, c[7:2], 1'b0}, 1'b1);
   endtask

   task automatic burst(input int at, input int cnt, input logic [7:0] v, input logic inc);
      for (int i = 0; i < cnt; i++)
         chk("beat", 8'(v + (inc ? i : 0)), beats[at + i]);
   endtask

   always @(posedge ck)
      rises++;

   // a beat is taken at every strobe toggle while data drives
   always @(posedge clk_sys)
   begin
      if (act_p === 1'b1)
         acts++;
      if (cal_p === 1'b1)
         cals++;
      if (sr_p === 1'b1)
         srs++;
      if (dq_oe === 1'b1 && (prev_oe !== 1'b1 || dqs !== prev_dqs))
         beats.push_back(dq);
      if (dq_oe === 1'b1 && prev_oe !== 1'b1)
      begin
         first_rise = rises;
         first_dqs = dqs;
      end
      if (dqs_oe === 1'b1 && prev_doe !== 1'b1 && dqs === 1'b0 && dq_oe === 1'b0)
         pre_ok++;
      prev_oe = dq_oe;
      prev_dqs = dqs;
      prev_doe = dqs_oe;
   end

   initial
   begin
      clk_sys = 1'b0;
      forever #2.5 clk_sys = ~clk_sys;
   end

   initial
   begin
      #100000;
      failures++;
      finish_test;
   end

   initial
   begin
      rst_b = 1'b0;
      cal_sup = 1'b0;
      rd_lat = 4'h3;
      burst_len = 6'h08;
      repeat (3) @(posedge clk_sys);
      #1 rst_b = 1'b1;
      repeat (6) @(posedge clk_sys);
      #1;
      foreach (rows[i])
      begin
         n = cals;
         k = srs;
         beats.delete();
         mr(rows[i].a, rows[i].d, !rows[i].wr);
         base = rises;
         mdm_ctrl_model_inst.idle(8);
         if (rows[i].wr)
            chk("wr", rows[i].e, {cals - n == 1, srs - k == 1, cal_kind, srf});
         else
         begin
            chk_n("mrd_n", 4, beats.size());
            chk_n("mrd_lat", base + 3, first_rise);
            burst(0, 4, rows[i].e, 1'b0);
         end
      end
      chk("arf", 4'hF, arf);
      cal_sup = 1'b1;
      n = cals;
      mr(mdm_pkg::MA_CAL_CODE, mdm_pkg::CAL_INIT, 1'b0);
      mdm_ctrl_model_inst.idle(4);
      chk_n("cal_sup", n, cals);
      cal_sup = 1'b0;
      n = acts;
      mdm_ctrl_model_inst.cmd({1'b0, 2'd2, 5'h1C, 2'b10}, 10'h0D5, 1'b1);
      mdm_ctrl_model_inst.idle(2);
      chk("act", {2'd2, 13'h1ABC}, {act_bank, act_row});
      beats.delete();
      mdm_ctrl_model_inst.cmd({1'b0, 2'd1, 5'h03, 2'b10}, 10'h011, 1'b0);
      mdm_ctrl_model_inst.cmd(10'h001, 10'h000, 1'b1);
      mdm_ctrl_model_inst.idle(8);
      chk_n("act_n", n + 1, acts);
      chk("act", {2'd2, 13'h1ABC}, {act_bank, act_row});
      chk_n("wr_beats", 0, beats.size());
      // every burst length, each with its own latency
      for (int j = 0; j < 3; j++)
      begin
         burst_len = 6'(4 << j);
         rd_lat = 4'(3 + j);
         beats.delete();
         k = pre_ok;
         rdc(8'hFC);
         base = rises;
         mdm_ctrl_model_inst.idle(14);
         chk_n("rd_n", 4 << j, beats.size());
         burst(0, 4 << j, 8'hFC, 1'b1);
         chk_n("rd_lat", base + 3 + j, first_rise);
         chk_n("pre", k + 1, pre_ok);
         chk("first_dqs", 1'b1, first_dqs);
         chk("oe_end", 2'b00, {dq_oe, dqs_oe});
      end
      rd_lat = 4'h3;
      burst_len = 6'h08;
      beats.delete();
      rdc(8'h10);
      mdm_ctrl_model_inst.idle(1);
      rdc(8'h40);
      mdm_ctrl_model_inst.idle(12);
      chk_n("intr_n", 12, beats.size());
      burst(0, 4, 8'h10, 1'b1);
      burst(4, 8, 8'h40, 1'b1);
      mr(mdm_pkg::MA_BANK_MASK, 8'h0F, 1'b0);
      mdm_ctrl_model_inst.idle(2);
      chk("srf", 4'h0, srf);
      rst_b = 1'b0;
      repeat (2) @(posedge clk_sys);
      #1;
      chk("rst", 10'h3FC, {srf, arf, dq_oe, dqs_oe});
      rst_b = 1'b1;
      repeat (6) @(posedge clk_sys);
      #1;
      // a length 16 burst after reset pushes twice the buffer depth through the data path
      burst_len = 6'h10;
      beats.delete();
      rdc(8'h80);
      base = rises;
      mdm_ctrl_model_inst.idle(12);
      chk_n("rst_rd_n", 16, beats.size());
      burst(0, 16, 8'h80, 1'b1);
      chk_n("rst_rd_lat", base + 3, first_rise);
      chk("rst_oe_end", 2'b00, {dq_oe, dqs_oe});
      burst_len = 6'h04;
      beats.delete();
      rdc(8'h20);
      rdc(8'h60);
      mdm_ctrl_model_inst.idle(6);
      chk_n("bl4_n", 4, beats.size());
      burst(0, 4, 8'h20, 1'b1);
      finish_test;
   end
endmodule // mdm_modereg_cmd_bench

`default_nettype wire
